// [sim/bsh_core_model.sv]
// Partner model: eight cores issuing hub instructions on command.
// Assumes requests are one-cycle pulses taken at the next clock edge.
module bsh_core_model
  import bsh_pkg::*;
#(
  parameter int NC = 8
) (
  input  wire logic          clock_in,    // System clock
  input  wire logic          rst_in,      // Async reset
  input  wire logic [NC-1:0] go_in,       // Issue command
  input  wire logic [NC-1:0] hub_done_in, // Finish pulse
  output logic      [NC-1:0] hub_req_out, // Request pulse
  output int                 bad_out,     // Bad waits
  output int                 seen_out,    // Finished count
  output int                 min_out,     // Shortest wait
  output int                 max_out      // Longest wait
);
  timeunit 1ns;
  timeprecision 1ps;
  int            age [NC];
  logic [NC-1:0] busy;
  // One instruction in flight per core, timed from the taking edge
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hub_req_out <= '0;
      busy = '0;
      bad_out = 0;
      seen_out = 0;
      min_out = 99;
      max_out = 0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (hub_done_in[c]) begin
          seen_out++;
          if (!busy[c] || age[c] < 7 || age[c] > 22) bad_out++;
          min_out = (age[c] < min_out) ? age[c] : min_out;
          max_out = (age[c] > max_out) ? age[c] : max_out;
          busy[c] = 1'b0;
        end
        age[c]++;
        if (hub_req_out[c]) begin
          busy[c] = 1'b1;
          age[c] = 0;
        end
        // A busy core never stacks a second request
        hub_req_out[c] <= go_in[c] && !busy[c];
      end
    end
  end
endmodule

// [sim/test_boot_shutdown_and_hub_rotation.sv]
// Self-checking bench for the boot, shutdown and hub block.
// Assumes bsh_pkg, bsh_hub and bsh_boot_ctrl are compiled first.
module test_boot_shutdown_and_hub_rotation;
  timeunit 1ns;
  timeprecision 1ps;
  import bsh_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  localparam int DIV = 4;
  localparam int PU  = 4;
  localparam int DL  = 4;
  logic        clock_in = 1'b0, rst_in = 1'b1, external_reset_input_n = 1'b1, brownout_in = 1'b0;
  logic        brownout_en_in = 1'b0, sw_restart_in = 1'b0, host_found_in = 1'b1, memory_found_in = 1'b0;
  logic        load_done_in = 1'b0, suspend_in = 1'b0, spr_by_index_in = 1'b1;
  logic [1:0]  clk_src_in = 2'h2;
  logic [7:0]  core_start_in = 8'h00, core_stop_in = 8'h00, core_drive_in = 8'hff, go = 8'h00;
  logic [8:0]  spr_index_in = 9'h004;
  logic [31:0] main_word_in = 32'h5a5a0001;
  logic        shutdown_out, pins_input_out, host_probe_out, memory_probe_out, loader_core0_out;
  logic        interp_core0_out, hub_en_out, load_we_out;
  logic [1:0]  clk_mode_out, clk_src_out;
  logic [7:0]  hub_req_in, core_run_out, core_pin_en_out, hub_done_out, grant_out;
  logic [8:0]  spr_addr_out, load_addr_out;
  logic [31:0] load_data_out, system_cycle_counter, cnt0;
  logic [2:0]  load_core_out;
  int          n_mismatch = 0, n_checks = 0, bad, seen, min_l, max_l, i, k;
  // Half period of 10 ns gives 50 MHz
  always #10ns clock_in = ~clock_in;
  // Short slow tick and delays keep the boot walk brief
  bsh_boot_ctrl #(.SLOW_DIV(DIV), .POWERUP_TICKS(PU), .DELAY_TICKS(DL)) i_dut (
    .clock_in, .rst_in, .external_reset_input_n, .brownout_in, .brownout_en_in, .sw_restart_in,
    .clk_src_in, .host_found_in, .memory_found_in, .load_done_in, .suspend_in, .core_start_in,
    .core_stop_in, .hub_req_in, .core_drive_in, .spr_index_in, .spr_by_index_in, .main_word_in,
    .clk_mode_out, .clk_src_out, .shutdown_out, .pins_input_out, .host_probe_out, .memory_probe_out,
    .loader_core0_out, .interp_core0_out, .core_run_out, .core_pin_en_out, .hub_done_out, .grant_out,
    .hub_en_out, .spr_addr_out, .load_we_out, .load_addr_out, .load_data_out, .load_core_out,
    .system_cycle_counter);
  bsh_core_model i_cores (.clock_in, .rst_in, .go_in(go), .hub_done_in(hub_done_out),
    .hub_req_out(hub_req_in), .bad_out(bad), .seen_out(seen), .min_out(min_l), .max_out(max_l));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Sample just after an edge so all updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // A spent wait bound ends the run
  task automatic tmo(input int c, input int lim);
    if (c >= lim) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      results();
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Slow clock over the delay, then fast clock and loader in core 0
  task automatic t_boot(input int lo);
    chk(clk_mode_out, 2'h1, "slow");
    for (i = 0; i < 200 && loader_core0_out !== 1'b1; i++) cyc(1);
    tmo(i, 200);
    chk(i >= lo, 1'b1, "delay");
    chk(clk_mode_out, 2'h2, "fast");
    chk({core_run_out[0], host_probe_out, memory_probe_out}, 3'h6, "host first");
  endtask
  // Clock stopped, pins released, no core left running
  task automatic t_down(input string why);
    for (i = 0; i < 4 && shutdown_out !== 1'b1; i++) cyc(1);
    tmo(i, 4);
    chk({pins_input_out, clk_mode_out, core_run_out, core_pin_en_out}, 19'h40000, why);
  endtask
  // Grants step through cores 0..7 on even cycles, period 16
  task automatic t_rot();
    logic h;
    for (i = 0; i < 20 && grant_out !== 8'h01; i++) cyc(1);
    tmo(i, 20);
    h = hub_en_out;
    for (k = 1; k <= 16; k++) begin
      cyc(1);
      chk(hub_en_out, !h, "hub rate");
      h = hub_en_out;
      chk(grant_out, k[0] ? 8'h00 : 8'h01 << (k[4:1] & 4'h7), "grant");
    end
  endtask
  // Requests from all 16 phases, then all cores together
  task automatic t_lat();
    // Only running cores may use the hub
    for (k = 1; k < 8; k++) begin
      @(posedge clock_in) core_start_in <= 8'h01 << k;
      @(posedge clock_in) core_start_in <= 8'h00;
      for (i = 0; i < 600 && core_run_out[k] !== 1'b1; i++) cyc(1);
      tmo(i, 600);
    end
    for (k = 0; k < 17; k++) begin
      for (i = 0; i < 20 && grant_out[0] !== 1'b1; i++) cyc(1);
      tmo(i, 20);
      repeat (k % 16 + 1) @(posedge clock_in);
      go <= (k == 16) ? 8'hff : 8'h08;
      @(posedge clock_in) go <= 8'h00;
      for (i = 0; i < 40 && seen < k + 1 + (k / 16) * 7; i++) cyc(1);
      tmo(i, 40);
    end
    chk(bad, 0, "wait range");
    chk(max_l - min_l, 15, "wait spread");
  endtask
  // Core 1 start: 496 words copied, 16 cleared, runs until stopped
  task automatic t_load();
    int nw;
    int nd;
    int na;
    nw = 0;
    nd = 0;
    na = 0;
    @(posedge clock_in) core_start_in <= 8'h02;
    @(posedge clock_in) core_start_in <= 8'h00;
    for (i = 0; i < 600 && nw < 512; i++) begin
      cyc(1);
      nw += (load_we_out === 1'b1);
      nd += (load_we_out === 1'b1 && load_data_out === main_word_in);
      na += (load_we_out === 1'b1 && load_addr_out === 9'(nw - 1) && load_core_out === 3'h1 &&
             (load_addr_out < 9'h1f0) == (load_data_out === main_word_in));
    end
    tmo(i, 600);
    chk(nd, 496, "copied");
    chk(na, 512, "in place");
    cyc(2);
    chk({core_run_out[1], core_pin_en_out[1]}, 2'h3, "runs");
    @(posedge clock_in) core_stop_in <= 8'h02;
    @(posedge clock_in) core_stop_in <= 8'h00;
    cyc(2);
    chk({core_run_out[1], core_pin_en_out[1]}, 2'h0, "off pins");
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    cyc(1);
    t_boot((PU + DL - 1) * DIV);
    @(posedge clock_in) load_done_in <= 1'b1;
    suspend_in <= 1'b1;
    cyc(2);
    chk({interp_core0_out, shutdown_out}, 2'h0, "suspend");
    @(posedge clock_in) clk_src_in <= 2'h1;
    cyc(1);
    chk(clk_src_out, 2'h1, "source");
    cnt0 = system_cycle_counter;
    cyc(5);
    chk(system_cycle_counter, cnt0 + 32'h5, "counter");
    chk(spr_addr_out, 9'h1f4, "index");
    @(posedge clock_in) spr_by_index_in <= 1'b0;
    spr_index_in <= 9'h1f7;
    cyc(1);
    chk(spr_addr_out, 9'h1f7, "address");
    t_rot();
    t_lat();
    t_load();
    @(posedge clock_in) external_reset_input_n <= 1'b0;
    host_found_in <= 1'b0;
    memory_found_in <= 1'b1;
    load_done_in <= 1'b0;
    suspend_in <= 1'b0;
    t_down("pin low");
    @(posedge clock_in) external_reset_input_n <= 1'b1;
    cyc(1);
    t_boot((DL - 1) * DIV);
    cyc(1);
    chk(memory_probe_out, 1'b1, "memory");
    @(posedge clock_in) load_done_in <= 1'b1;
    cyc(2);
    chk(interp_core0_out, 1'b1, "interpreter");
    @(posedge clock_in) sw_restart_in <= 1'b1;
    t_down("restart");
    @(posedge clock_in) sw_restart_in <= 1'b0;
    cyc(1);
    t_boot((DL - 1) * DIV);
    @(posedge clock_in) brownout_in <= 1'b1;
    cyc(3);
    chk(shutdown_out, 1'b0, "detector off");
    @(posedge clock_in) brownout_en_in <= 1'b1;
    t_down("brown-out");
    @(posedge clock_in) brownout_in <= 1'b0;
    memory_found_in <= 1'b0;
    load_done_in <= 1'b0;
    cyc(1);
    t_boot((DL - 1) * DIV);
    t_down("none found");
    results();
  end
endmodule

// [verilog/bsh_boot_ctrl.sv]
// Boot sequencer, shutdown control, hub, core start and system counter.
// Assumes loader status, pins and core requests are synchronous inputs.
//
// Summary of operation
// RULE1: slow clock, delay, fast clock, then loader
// RULE2: boot after power-up, reset rise, restart
// RULE3: loader started in core 0
// RULE4: loader checks host lines first
// RULE5: no host: copy 32 KB memory image
// RULE6: nothing found: stop core 0, shutdown
// RULE7: after load, core 0 runs interpreter
// RULE8: shutdown stops clock, pins become inputs
// RULE9: shutdown on brown-out, reset low, restart
// RULE10: leave shutdown when brown-out clear, reset high
// RULE11: hub rotates cores 0 through 7
// RULE12: hub runs at half system rate
// RULE13: one window per core per 16 cycles
// RULE14: hub instruction waits then takes 7 cycles
// RULE15: start loads words 0-495, clears 496-511
// RULE16: core runs from word 0 until stopped
// RULE17: all cores share one system clock
// RULE18: 512 local words, last 16 special
// RULE19: special registers by address or index
// RULE20: pins and counter readable by all cores
// RULE21: clock source chosen by configuration
// RULE22: everything else clocked by system clock
// RULE23: stopped core drives no pins
// RULE24: free-running 32-bit cycle counter
// RULE25: hub slot four-bit counter modulo 16
// RULE26: reset delay timed in slow ticks
`include "bsh_cfg.svh"
module bsh_boot_ctrl
  import bsh_pkg::*;
#(
  parameter int NCORES        = `BSH_NUM_CORES,
  parameter int SLOW_DIV      = `BSH_SLOW_DIV,
  parameter int POWERUP_TICKS = `BSH_POWERUP_TICKS,
  parameter int DELAY_TICKS   = `BSH_DELAY_TICKS
) (
  input  wire logic               clock_in,               // 50 MHz clock
  input  wire logic               rst_in,                 // Async reset
  input  wire logic               external_reset_input_n, // Reset pin level
  input  wire logic               brownout_in,            // Brown-out level
  input  wire logic               brownout_en_in,         // Detector enabled
  input  wire logic               sw_restart_in,          // Restart request
  input  wire logic [1:0]         clk_src_in,             // Clock source select
  input  wire logic               host_found_in,          // Host seen on lines
  input  wire logic               memory_found_in,        // Memory answered
  input  wire logic               load_done_in,           // Image load ended
  input  wire logic               suspend_in,             // Host suspend
  input  wire logic [NCORES-1:0]  core_start_in,          // Start pulse per core
  input  wire logic [NCORES-1:0]  core_stop_in,           // Stop pulse per core
  input  wire logic [NCORES-1:0]  hub_req_in,             // Hub instr ready
  input  wire logic [NCORES-1:0]  core_drive_in,          // Core wants pins
  input  wire logic [8:0]         spr_index_in,           // Local addr or index
  input  wire logic               spr_by_index_in,        // Index form used
  input  wire logic [31:0]        main_word_in,           // Main memory word
  output logic [1:0]              clk_mode_out,           // Stopped/slow/fast
  output logic [1:0]              clk_src_out,            // Active clock source
  output logic                    shutdown_out,           // Chip in shutdown
  output logic                    pins_input_out,         // All pins inputs
  output logic                    host_probe_out,         // Probing host lines
  output logic                    memory_probe_out,       // Probing memory lines
  output logic                    loader_core0_out,       // Loader in core 0
  output logic                    interp_core0_out,       // Interpreter core 0
  output logic [NCORES-1:0]       core_run_out,           // Core running
  output logic [NCORES-1:0]       core_pin_en_out,        // Allowed pin drive
  output logic [NCORES-1:0]       hub_done_out,           // Hub instr finished
  output logic [NCORES-1:0]       grant_out,              // Hub window pulse
  output logic                    hub_en_out,             // Half-rate enable
  output logic [8:0]              spr_addr_out,           // Resolved address
  output logic                    load_we_out,            // Local write strobe
  output logic [8:0]              load_addr_out,          // Local write address
  output logic [31:0]             load_data_out,          // Local write data
  output logic [2:0]              load_core_out,          // Core being loaded
  output logic [31:0]             system_cycle_counter    // Free cycle count
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bsh_phase_t         phase;
    logic [1:0]         clk;
    logic [1:0]         src;
    logic [15:0]        div;
    logic [15:0]        ticks;
    logic               shut;
    logic               pins_in;
    logic [1:0]         probe;
    logic               host_phase;
    logic               loader;
    logic               interp;
    logic [NCORES-1:0]  run;
    logic [NCORES-1:0]  pin_en;
    logic [NCORES-1:0]  pending;
    logic [NCORES-1:0]  done;
    logic [3*NCORES-1:0] exec_cnt;
    logic               loading;
    logic [2:0]         load_core;
    logic [8:0]         load_addr;
    logic [8:0]         wr_addr;
    logic               load_we;
    logic [31:0]        load_data;
    logic [8:0]         spr_addr;
    logic [31:0]        cnt;
  } bsh_state_t;
  bsh_state_t s_r, s_nxt;

  logic [NCORES-1:0] grant_w;
  logic              hub_en_w;
  logic              slow_tick;
  logic              shut_cond;

  // Local index form maps into the top 16 words
  function automatic logic [8:0] spr_map(input logic [8:0] a, input logic by_idx);
    spr_map = by_idx ? (`BSH_SPR_BASE | {5'h00, a[3:0]}) : a;
  endfunction

  // Hub shares the single system clock; gated while clock is stopped
  bsh_hub #(
    .NCORES (NCORES)
  ) u_hub (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .run_in     (s_r.clk != 2'(CLK_STOPPED)),
    .hub_en_out (hub_en_w),
    .grant_out  (grant_w)
  );

  // Slow tick from divider so the delay is valid before fast clock
  assign slow_tick = (s_r.div == 16'(SLOW_DIV - 1));
  // Reset pin low, restart, or enabled brown-out forces shutdown
  assign shut_cond = !external_reset_input_n || sw_restart_in ||
                     (brownout_en_in && brownout_in);          // see RULE9

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = '0;
    s_nxt.load_we = 1'b0;
    // Counter never cleared by boot, only by chip reset flop default
    s_nxt.cnt = s_r.cnt + 32'h1;                              // see RULE24, RULE20
    s_nxt.div = slow_tick ? 16'h0 : s_r.div + 16'h1;
    s_nxt.spr_addr = spr_map(spr_index_in, spr_by_index_in);  // see RULE19, RULE18
    s_nxt.src = clk_src_in;                                   // see RULE21

    case (s_r.phase)
      ST_SHUTDOWN: begin
        s_nxt.clk = 2'(CLK_STOPPED);                          // see RULE8
        s_nxt.run = '0;
        s_nxt.loader = 1'b0;
        s_nxt.interp = 1'b0;
        // Leave only when all three conditions hold together
        if (!brownout_in && external_reset_input_n && !sw_restart_in) begin // see RULE10, RULE2
          s_nxt.phase = ST_SLOW_DELAY;
          s_nxt.clk = 2'(CLK_SLOW);                           // see RULE1
          s_nxt.ticks = '0;
        end
      end
      ST_SETTLE: begin
        // Power-up settling before the reset delay
        s_nxt.clk = 2'(CLK_SLOW);
        if (slow_tick) begin
          s_nxt.ticks = s_r.ticks + 16'h1;
          if (s_r.ticks == 16'(POWERUP_TICKS - 1)) begin      // see RULE2
            s_nxt.phase = ST_SLOW_DELAY;
            s_nxt.ticks = '0;
          end
        end
      end
      ST_SLOW_DELAY: begin
        if (slow_tick) begin
          s_nxt.ticks = s_r.ticks + 16'h1;                    // see RULE26
          if (s_r.ticks == 16'(DELAY_TICKS - 1)) begin
            s_nxt.phase = ST_LOADER;
            s_nxt.clk = 2'(CLK_FAST);                         // see RULE1
            s_nxt.loader = 1'b1;                              // see RULE3
            s_nxt.run = NCORES'(1);
            s_nxt.host_phase = 1'b1;
          end
        end
      end
      ST_LOADER: begin
        // Host first; memory only when no host answered
        if (s_r.host_phase) begin
          if (host_found_in) begin                            // see RULE4
            if (load_done_in) s_nxt.phase = ST_RUN;
          end else begin
            s_nxt.host_phase = 1'b0;                          // see RULE5
          end
        end else if (memory_found_in) begin
          if (load_done_in) s_nxt.phase = ST_RUN;
        end else begin
          s_nxt.phase = ST_SHUTDOWN;                          // see RULE6
          s_nxt.run = '0;
          s_nxt.loader = 1'b0;
          s_nxt.clk = 2'(CLK_STOPPED);
        end
        if (s_nxt.phase == ST_RUN) begin
          s_nxt.loader = 1'b0;
          s_nxt.interp = !suspend_in;                         // see RULE7
        end
      end
      ST_RUN: begin
        s_nxt.clk = 2'(CLK_FAST);
      end
      default: s_nxt.phase = ST_SHUTDOWN;
    endcase

    // Per-core start/stop and hub instruction timing
    if (s_r.phase == ST_RUN) begin
      for (int i = 0; i < NCORES; i++) begin
        if (core_stop_in[i]) s_nxt.run[i] = 1'b0;             // see RULE16
        if (core_start_in[i] && !s_r.loading) begin
          s_nxt.loading = 1'b1;                               // see RULE15
          s_nxt.load_core = 3'(i);
          s_nxt.load_addr = '0;
          s_nxt.run[i] = 1'b0;
        end
        if (hub_req_in[i] && s_r.run[i]) s_nxt.pending[i] = 1'b1;
        // Wait for own window, then seven cycles of execution
        if (s_r.pending[i] && grant_w[i] && s_r.exec_cnt[3*i +: 3] == 3'h0) begin
          s_nxt.exec_cnt[3*i +: 3] = 3'(`BSH_HUB_EXEC - 1);  // see RULE14
          s_nxt.pending[i] = 1'b0;
        end else if (s_r.exec_cnt[3*i +: 3] != 3'h0) begin
          s_nxt.exec_cnt[3*i +: 3] = s_r.exec_cnt[3*i +: 3] - 3'h1;
          if (s_r.exec_cnt[3*i +: 3] == 3'h1) s_nxt.done[i] = 1'b1;
        end
      end
    end

    // Sequential local load, zero fill of the special words
    if (s_r.loading) begin
      s_nxt.load_we = 1'b1;
      s_nxt.wr_addr = s_r.load_addr;
      s_nxt.load_data = (s_r.load_addr < 9'(`BSH_LOAD_WORDS)) ? main_word_in : 32'h0;
      s_nxt.load_addr = s_r.load_addr + 9'h1;
      if (s_r.load_addr == 9'(`BSH_LOCAL_WORDS - 1)) begin
        s_nxt.loading = 1'b0;
        s_nxt.run[s_r.load_core] = 1'b1;                      // see RULE16
      end
    end
    // Stopped cores lose pin influence
    s_nxt.pin_en = s_nxt.run & core_drive_in;                 // see RULE23

    // Shutdown events override phase, clock, cores, hub waits and loading; reset rise rearms boot
    if (shut_cond && s_r.phase != ST_SHUTDOWN) begin
      s_nxt.phase = ST_SHUTDOWN;                              // see RULE9, RULE8
      s_nxt.clk = 2'(CLK_STOPPED);
      s_nxt.run = '0;
      s_nxt.pin_en = '0;
      s_nxt.pending = '0;
      s_nxt.exec_cnt = '0;
      s_nxt.loading = 1'b0;
      s_nxt.loader = 1'b0;
      s_nxt.interp = 1'b0;
    end
    // Status decoded ahead so outputs leave flops
    s_nxt.shut    = (s_nxt.phase == ST_SHUTDOWN);
    s_nxt.pins_in = (s_nxt.phase != ST_RUN) && (s_nxt.phase != ST_LOADER);
    s_nxt.probe   = (s_nxt.phase == ST_LOADER) ? {s_nxt.host_phase, !s_nxt.host_phase} : 2'h0;
  end

  // Single clock for all cores and this controller
  always_ff @(posedge clock_in or posedge rst_in) begin       // see RULE17
    if (rst_in) begin
      s_r <= '0;
      s_r.phase <= ST_SETTLE;
      s_r.clk <= 2'(CLK_SLOW);
      s_r.pins_in <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      grant_out  <= '0;
      hub_en_out <= 1'b0;
    end else begin
      grant_out  <= grant_w;
      hub_en_out <= hub_en_w;
    end
  end

  assign clk_mode_out         = s_r.clk;
  assign clk_src_out          = s_r.src;
  assign shutdown_out         = s_r.shut;
  assign pins_input_out       = s_r.pins_in;
  assign host_probe_out       = s_r.probe[1];
  assign memory_probe_out     = s_r.probe[0];
  assign loader_core0_out     = s_r.loader;
  assign interp_core0_out     = s_r.interp;
  assign core_run_out         = s_r.run;
  assign core_pin_en_out      = s_r.pin_en;
  assign hub_done_out         = s_r.done;
  assign spr_addr_out         = s_r.spr_addr;
  assign load_we_out          = s_r.load_we;
  assign load_addr_out        = s_r.wr_addr;
  assign load_data_out        = s_r.load_data;
  assign load_core_out        = s_r.load_core;
  assign system_cycle_counter = s_r.cnt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_shut_clock_stop: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE8
    (s_r.phase != ST_SHUTDOWN && shut_cond) |=> shutdown_out && clk_mode_out == 2'(CLK_STOPPED))
    else $error("shutdown not entered");
  a_fast_before_loader: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE1
    $rose(loader_core0_out) |-> clk_mode_out == 2'(CLK_FAST))
    else $error("loader started on slow clock");
  a_loader_core0: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE3
    $rose(loader_core0_out) |-> core_run_out == NCORES'(1))
    else $error("loader not alone in core 0");
  a_counter_step: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE24
    !$past(rst_in) |-> system_cycle_counter == $past(system_cycle_counter) + 32'h1)
    else $error("counter did not advance");
  a_stopped_no_pins: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE23
    (core_pin_en_out & ~core_run_out) == '0)
    else $error("stopped core drives pins");
  a_no_mem_shutdown: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE6
    (memory_probe_out && !memory_found_in) |=> shutdown_out)
    else $error("no shutdown after failed probe");
  a_load_zero_fill: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE15
    (load_we_out && load_addr_out >= 9'(`BSH_LOAD_WORDS)) |-> load_data_out == 32'h0)
    else $error("special word not cleared");
  a_spr_index_map: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE19
    (spr_by_index_in && spr_index_in == 9'h004) |=> spr_addr_out == `BSH_OUTPUT_LATCH_A_ADDR)
    else $error("index 4 not output latch");
  a_hub_exec_len: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE14
    (s_r.pending[0] && grant_w[0] && s_r.exec_cnt[2:0] == 3'h0 && !shut_cond
     && s_r.phase == ST_RUN) |-> ##7 hub_done_out[0])
    else $error("hub instruction length wrong");
  a_exit_shutdown: assert property (@(posedge clock_in) disable iff (rst_in) // see RULE10
    (shutdown_out && (brownout_in || !external_reset_input_n)) |=> shutdown_out)
    else $error("left shutdown too early");

  c_loader_run: cover property (@(posedge clock_in) disable iff (rst_in) $rose(interp_core0_out));
  c_shutdown: cover property (@(posedge clock_in) disable iff (rst_in) $rose(shutdown_out));
  c_hub_done: cover property (@(posedge clock_in) disable iff (rst_in) hub_done_out[0]);
  c_core_load: cover property (@(posedge clock_in) disable iff (rst_in) $fell(s_r.loading));
endmodule

// [verilog/bsh_cfg.svh]
// Timing, sizing and reset constants for the boot, shutdown and hub block.
// Assumes a 50 MHz system clock and inclusion by bare name.
`ifndef BSH_CFG_SVH
`define BSH_CFG_SVH
`define BSH_CLK_HZ          50000000
`define BSH_SLOW_HZ         20000
`define BSH_POWERUP_MS      100
`define BSH_RESET_DELAY_MS  50
`define BSH_SLOW_DIV        (`BSH_CLK_HZ / `BSH_SLOW_HZ)
`define BSH_POWERUP_TICKS   (`BSH_POWERUP_MS * `BSH_SLOW_HZ / 1000)
`define BSH_DELAY_TICKS     (`BSH_RESET_DELAY_MS * `BSH_SLOW_HZ / 1000)
`define BSH_NUM_CORES       8
`define BSH_HUB_PERIOD      16
`define BSH_HUB_EXEC        7
`define BSH_LOCAL_WORDS     512
`define BSH_LOAD_WORDS      496
`define BSH_SPR_BASE        9'h1f0
`define BSH_OUTPUT_LATCH_A_ADDR       9'h1f4
`define BSH_IMAGE_BYTES     32768
`endif

// [verilog/bsh_hub.sv]
// Hub slot rotation: one grant per core per 16 system cycles.
// Assumes a single system clock; hub rate is an enable pulse.
`include "bsh_cfg.svh"
module bsh_hub
  import bsh_pkg::*;
#(
  parameter int NCORES = `BSH_NUM_CORES
) (
  input  wire logic              clock_in,   // System clock
  input  wire logic              rst_in,     // Async reset
  input  wire logic              run_in,     // Clock running
  output logic                   hub_en_out, // Half-rate enable
  output logic [NCORES-1:0]      grant_out   // Per-core window pulse
);
  typedef struct packed {
    logic [3:0]        slot;
    logic              en;
    logic [NCORES-1:0] grant;
  } bsh_hub_state_t;
  bsh_hub_state_t s_r, s_nxt;

  // Slot counter wraps every 16 cycles regardless of active cores
  always_comb begin
    s_nxt = s_r;
    s_nxt.grant = '0;
    if (run_in) begin
      s_nxt.slot = s_r.slot + 4'h1;                 // see RULE25
      s_nxt.en = ~s_r.slot[0];                      // see RULE12, RULE22
      if (s_r.slot[0] == 1'b0)
        s_nxt.grant[s_r.slot[3:1]] = 1'b1;          // see RULE11, RULE13
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hub_en_out = s_r.en;
  assign grant_out  = s_r.grant;

  a_grant_period: assert property (@(posedge clock_in) disable iff (rst_in)
    (run_in && grant_out[0]) ##1 run_in [*8] |-> !grant_out[0]) // see RULE13
    else $error("core 0 granted too soon");
  a_grant_onehot: assert property (@(posedge clock_in) disable iff (rst_in)
    $onehot0(grant_out)) // see RULE11
    else $error("more than one grant");
endmodule

// [verilog/bsh_pkg.sv]
// Types shared by the boot, shutdown and hub block.
// Assumes bsh_cfg.svh is on the include path.
package bsh_pkg;
  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_SETTLE, ST_SLOW_DELAY, ST_LOADER, ST_RUN
  } bsh_phase_t;
  typedef enum logic [1:0] {
    CLK_STOPPED, CLK_SLOW, CLK_FAST
  } bsh_clkmode_t;
  typedef struct packed {
    logic brownout_ind;
    logic brownout_en;
    logic ext_reset_n;
    logic sw_restart;
  } bsh_chipctl_t;
  typedef struct packed {
    logic host_found;
    logic memory_found;
    logic load_done;
    logic suspend;
  } bsh_loader_t;
endpackage
